// file: logic/pacc_unit.sv
// Pulse accumulator with count, flags, control and timer clock select
`timescale 1ns/100ps
`default_nettype none
module pacc_unit
  import pacc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire pacc_bus_t bus,
  output logic [15:0] rdata,
  input wire logic channel7_pin,
  input wire logic timer_on,
  input wire logic fast_flag_clear,
  input wire logic presc_div64_tick,
  input wire logic presc_tick,
  output logic timer_clk_tick,
  output logic ovf_irq,
  output logic input_irq
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic ctl_hit = bus.addr == PACC_ADDR_CTL;
  wire logic flg_hit = bus.addr == PACC_ADDR_FLG;
  wire logic cnt_hit = bus.addr == PACC_ADDR_CNT;
  wire logic ctl_wr = bus.wr && ctl_hit;
  wire logic flg_wr = bus.wr && flg_hit;
  wire logic cnt_wr = bus.wr && cnt_hit;
  wire logic cnt_acc = (bus.wr || bus.rd) && cnt_hit;
  wire logic fast_clr = fast_flag_clear && cnt_acc;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [7:0] ctl_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_q <= PACC_CTL_RST;
    end else if (ctl_wr) begin
      ctl_q <= bus.wdata[7:0];
    end
  end
  pacc_ctl_t ctl;
  assign ctl.enable = ctl_q[PACC_BIT_EN];
  assign ctl.mode_sel = ctl_q[PACC_BIT_MOD];
  assign ctl.edge_sel = ctl_q[PACC_BIT_EDGE];
  assign ctl.clk_sel = ctl_q[PACC_BIT_CLKH:PACC_BIT_CLKL];
  assign ctl.ovf_irq_en = ctl_q[PACC_BIT_OVI];
  assign ctl.input_irq_en = ctl_q[PACC_BIT_PAI];

  // ----------------------------------------
  // Pin synchroniser and edges
  // ----------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic pin_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      sync1_q <= channel7_pin;
      sync2_q <= sync1_q;
      pin_q <= sync2_q;
    end
  end
  wire logic rise = sync2_q && !pin_q;
  wire logic fall = !sync2_q && pin_q;
  // Event edge: 0 falling, 1 rising
  wire logic ev_edge = ctl.edge_sel ? rise : fall;
  // Gate active level: 0 high, 1 low
  wire logic gate_lvl = ctl.edge_sel ? !sync2_q : sync2_q;
  // Trailing edge of the gate
  wire logic gate_trail = ctl.edge_sel ? rise : fall;
  wire logic div64 = presc_div64_tick && timer_on;
  wire logic ev_mode = ctl.enable && !ctl.mode_sel;
  wire logic gt_mode = ctl.enable && ctl.mode_sel;
  wire logic inc = ev_mode ? ev_edge : (gt_mode && gate_lvl && div64);
  wire logic in_evt = (ev_mode && ev_edge) || (gt_mode && gate_trail);

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire logic wrap = inc && !cnt_wr && cnt_q == PACC_CNT_MAX;
  assign cnt_d = cnt_wr ? bus.wdata : (inc ? cnt_q + PACC_CNT_ONE : cnt_q);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= PACC_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Flags, set wins over clear
  // ----------------------------------------
  logic ovf_q;
  logic if_q;
  wire logic ovf_clr = fast_clr || (flg_wr && bus.wdata[PACC_FLG_OVF]);
  wire logic if_clr = fast_clr || (flg_wr && bus.wdata[PACC_FLG_IF]);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      if_q <= 1'b0;
    end else begin
      ovf_q <= wrap || (ovf_q && !ovf_clr);
      if_q <= in_evt || (if_q && !if_clr);
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  wire logic ovf_irq_d = (wrap || (ovf_q && !ovf_clr)) && ctl.ovf_irq_en;
  wire logic in_irq_d = (in_evt || (if_q && !if_clr)) && ctl.input_irq_en;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_irq <= 1'b0;
      input_irq <= 1'b0;
    end else begin
      ovf_irq <= ovf_irq_d;
      input_irq <= in_irq_d;
    end
  end

  // ----------------------------------------
  // Timer counter clock select
  // ----------------------------------------
  logic [7:0] div256_q;
  logic [15:0] div64k_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div256_q <= PACC_DIV256_MAX;
      div64k_q <= PACC_DIV64K_MAX;
    end else if (inc) begin
      div256_q <= div256_q - 8'h01;
      div64k_q <= div64k_q - 16'h0001;
    end
  end
  wire logic tick256 = inc && div256_q == 8'h00;
  wire logic tick64k = inc && div64k_q == 16'h0000;
  // Uses the live control bits, so a write takes effect next cycle
  wire logic [1:0] sel = ctl.enable ? ctl.clk_sel : PACC_CLK_PRESC;
  wire logic tick_d = (sel == PACC_CLK_PRESC) ? presc_tick :
                      (sel == PACC_CLK_ACC) ? inc :
                      (sel == PACC_CLK_ACC256) ? tick256 : tick64k;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_clk_tick <= 1'b0;
    end else begin
      timer_clk_tick <= tick_d;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [15:0] rd_mux =
    ctl_hit ? {8'h00, ctl_q} :
    flg_hit ? {14'h0000, ovf_q, if_q} :
    cnt_hit ? cnt_q : 16'h0000;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ovf_on_wrap: assert property (@(posedge mclk) disable iff (rst)
    wrap |=> ovf_q && cnt_q == PACC_CNT_RST)
    else $error("overflow flag not set on wrap");
  a_if_clear: assert property (@(posedge mclk) disable iff (rst)
    flg_wr && bus.wdata[PACC_FLG_IF] && !in_evt |=> !if_q)
    else $error("input flag not cleared");
  a_fast_clear: assert property (@(posedge mclk) disable iff (rst)
    fast_clr && !wrap && !in_evt |=> !ovf_q && !if_q)
    else $error("fast clear failed");
  a_no_count_off: assert property (@(posedge mclk) disable iff (rst)
    !ctl.enable && !cnt_wr |=> $stable(cnt_q))
    else $error("count moved while disabled");
  a_gated_timer: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && !timer_on && !cnt_wr |=> $stable(cnt_q))
    else $error("gated count without timer");
  a_ev_count: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && ev_edge && !cnt_wr |=> cnt_q == $past(cnt_q) + PACC_CNT_ONE)
    else $error("event edge not counted");
  a_presc_sel: assert property (@(posedge mclk) disable iff (rst)
    !ctl.enable |=> timer_clk_tick == $past(presc_tick))
    else $error("prescaler clock not used");
  a_ovf_irq: assert property (@(posedge mclk) disable iff (rst)
    ##1 ovf_irq == ($past(ovf_irq_d)) && (!ovf_irq || $past(ctl.ovf_irq_en)))
    else $error("overflow irq mismatch");
  a_in_irq: assert property (@(posedge mclk) disable iff (rst)
    if_q && ctl.input_irq_en && !if_clr |=> input_irq)
    else $error("input irq missing");
  a_cnt_write: assert property (@(posedge mclk) disable iff (rst)
    cnt_wr |=> cnt_q == $past(bus.wdata))
    else $error("count write lost");

  // ----------------------------------------
  // Control write, synchroniser, counting and divider assertions
  // ----------------------------------------
  a_ctl_write: assert property (@(posedge mclk) disable iff (rst)
    ctl_wr |=> ctl_q == $past(bus.wdata[7:0]))
    else $error("control write lost");
  a_ctl_hold: assert property (@(posedge mclk) disable iff (rst)
    !ctl_wr |=> $stable(ctl_q))
    else $error("control changed unwritten");
  a_ev_fall: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && !ctl.edge_sel && fall && !cnt_wr |=>
    cnt_q == $past(cnt_q) + PACC_CNT_ONE)
    else $error("falling edge not counted");
  a_ev_rise: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && ctl.edge_sel && rise && !cnt_wr |=>
    cnt_q == $past(cnt_q) + PACC_CNT_ONE)
    else $error("rising edge not counted");
  a_ev_quiet: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && !ev_edge && !cnt_wr |=> $stable(cnt_q))
    else $error("count moved without edge");
  a_ev_no_tmr: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && ev_edge && !timer_on && !cnt_wr |=>
    cnt_q == $past(cnt_q) + PACC_CNT_ONE)
    else $error("event lost with timer off");
  a_gt_count: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && gate_lvl && div64 && !cnt_wr |=>
    cnt_q == $past(cnt_q) + PACC_CNT_ONE)
    else $error("gated tick not counted");
  a_gt_no_tick: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && !div64 && !cnt_wr |=> $stable(cnt_q))
    else $error("gated count without tick");
  a_gt_closed: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && !gate_lvl && !cnt_wr |=> $stable(cnt_q))
    else $error("count while gate closed");
  a_sync_stage: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> sync2_q == $past(sync1_q))
    else $error("synchroniser skipped");
  a_cnt_hold: assert property (@(posedge mclk) disable iff (rst)
    !inc && !cnt_wr |=> $stable(cnt_q))
    else $error("count moved idle");
  a_div_lock: assert property (@(posedge mclk) disable iff (rst)
    div64k_q[7:0] == div256_q)
    else $error("dividers out of step");
  a_div_nest: assert property (@(posedge mclk) disable iff (rst)
    tick64k |-> tick256)
    else $error("div65536 tick off div256");
  a_div_step: assert property (@(posedge mclk) disable iff (rst)
    inc |=> div256_q == $past(div256_q) - 8'h01)
    else $error("div256 step lost");
  a_div_hold: assert property (@(posedge mclk) disable iff (rst)
    !inc |=> $stable(div64k_q))
    else $error("divider moved idle");

  // ----------------------------------------
  // Flag and interrupt assertions
  // ----------------------------------------
  a_ev_flag: assert property (@(posedge mclk) disable iff (rst)
    ev_mode && ev_edge |=> if_q)
    else $error("event flag not set");
  a_gt_fall: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && !ctl.edge_sel && fall |=> if_q)
    else $error("falling trail not flagged");
  a_gt_rise: assert property (@(posedge mclk) disable iff (rst)
    gt_mode && ctl.edge_sel && rise |=> if_q)
    else $error("rising trail not flagged");
  a_if_hold: assert property (@(posedge mclk) disable iff (rst)
    if_q && !if_clr |=> if_q)
    else $error("input flag lost");
  a_if_no_set: assert property (@(posedge mclk) disable iff (rst)
    !if_q && !in_evt |=> !if_q)
    else $error("input flag set idle");
  a_if_keep: assert property (@(posedge mclk) disable iff (rst)
    flg_wr && !bus.wdata[PACC_FLG_IF] && if_q |=> if_q)
    else $error("input flag cleared by zero");
  a_off_flag: assert property (@(posedge mclk) disable iff (rst)
    !ctl.enable && !if_q |=> !if_q)
    else $error("flag set while disabled");
  a_ovf_hold: assert property (@(posedge mclk) disable iff (rst)
    ovf_q && !ovf_clr |=> ovf_q)
    else $error("overflow flag lost");
  a_ovf_no_set: assert property (@(posedge mclk) disable iff (rst)
    !ovf_q && !wrap |=> !ovf_q)
    else $error("overflow flag set idle");
  a_ovf_clear: assert property (@(posedge mclk) disable iff (rst)
    flg_wr && bus.wdata[PACC_FLG_OVF] && !wrap |=> !ovf_q)
    else $error("overflow flag not cleared");
  a_max_wrap: assert property (@(posedge mclk) disable iff (rst)
    inc && !cnt_wr && cnt_q == PACC_CNT_MAX |=> ovf_q)
    else $error("wrap not flagged");
  a_fast_ovf: assert property (@(posedge mclk) disable iff (rst)
    fast_clr && !wrap |=> !ovf_q)
    else $error("fast clear kept overflow");
  a_fast_if: assert property (@(posedge mclk) disable iff (rst)
    fast_clr && !in_evt |=> !if_q)
    else $error("fast clear kept input flag");
  a_slow_keep: assert property (@(posedge mclk) disable iff (rst)
    !fast_flag_clear && cnt_acc && if_q |=> if_q)
    else $error("count access cleared flag");
  a_ovf_irq_on: assert property (@(posedge mclk) disable iff (rst)
    ovf_q && ctl.ovf_irq_en && !ovf_clr |=> ovf_irq)
    else $error("overflow irq missing");
  a_ovf_irq_off: assert property (@(posedge mclk) disable iff (rst)
    !ctl.ovf_irq_en |=> !ovf_irq)
    else $error("overflow irq not inhibited");
  a_in_irq_off: assert property (@(posedge mclk) disable iff (rst)
    !ctl.input_irq_en |=> !input_irq)
    else $error("input irq not inhibited");
  a_in_irq_flg: assert property (@(posedge mclk) disable iff (rst)
    input_irq |-> if_q)
    else $error("input irq without flag");
  a_in_irq_none: assert property (@(posedge mclk) disable iff (rst)
    !if_q && !in_evt |=> !input_irq)
    else $error("input irq with no cause");

  // ----------------------------------------
  // Clock select and read assertions
  // ----------------------------------------
  a_sel_presc: assert property (@(posedge mclk) disable iff (rst)
    ctl.enable && ctl.clk_sel == PACC_CLK_PRESC |=>
    timer_clk_tick == $past(presc_tick))
    else $error("prescaler select wrong");
  a_sel_acc: assert property (@(posedge mclk) disable iff (rst)
    ctl.enable && ctl.clk_sel == PACC_CLK_ACC |=>
    timer_clk_tick == $past(inc))
    else $error("accumulator select wrong");
  a_sel_256: assert property (@(posedge mclk) disable iff (rst)
    ctl.enable && ctl.clk_sel == PACC_CLK_ACC256 |=>
    timer_clk_tick == $past(tick256))
    else $error("div256 select wrong");
  a_sel_64k: assert property (@(posedge mclk) disable iff (rst)
    ctl.enable && ctl.clk_sel == PACC_CLK_ACC64K |=>
    timer_clk_tick == $past(tick64k))
    else $error("div65536 select wrong");
  a_sel_switch: assert property (@(posedge mclk) disable iff (rst)
    ctl_wr && bus.wdata[PACC_BIT_EN] &&
    bus.wdata[PACC_BIT_CLKH:PACC_BIT_CLKL] == PACC_CLK_ACC |=>
    ##1 timer_clk_tick == $past(inc))
    else $error("clock switch deferred");
  a_off_sel: assert property (@(posedge mclk) disable iff (rst)
    !ctl.enable |-> sel == PACC_CLK_PRESC)
    else $error("select ignored disable");
  a_rd_idle: assert property (@(posedge mclk) disable iff (rst)
    !bus.rd |=> rdata == 16'h0000)
    else $error("read data not idle");
  a_rd_cnt: assert property (@(posedge mclk) disable iff (rst)
    bus.rd && cnt_hit |=> rdata == $past(cnt_q))
    else $error("count read wrong");
  a_rd_ctl: assert property (@(posedge mclk) disable iff (rst)
    bus.rd && ctl_hit |=> rdata == {8'h00, $past(ctl_q)})
    else $error("control read wrong");
  a_rd_flg: assert property (@(posedge mclk) disable iff (rst)
    bus.rd && flg_hit |=> rdata[1:0] == {$past(ovf_q), $past(if_q)})
    else $error("flag read wrong");

endmodule // pacc_unit
`default_nettype wire

// file: logic/pacc_pkg.sv
// Package of constants and types for the 16-bit pulse accumulator
package pacc_pkg;
  localparam logic [7:0] PACC_ADDR_CTL = 8'h20;
  localparam logic [7:0] PACC_ADDR_FLG = 8'h21;
  localparam logic [7:0] PACC_ADDR_CNT = 8'h22;
  localparam int PACC_BIT_EN = 6;
  localparam int PACC_BIT_MOD = 5;
  localparam int PACC_BIT_EDGE = 4;
  localparam int PACC_BIT_CLKH = 3;
  localparam int PACC_BIT_CLKL = 2;
  localparam int PACC_BIT_OVI = 1;
  localparam int PACC_BIT_PAI = 0;
  localparam int PACC_FLG_OVF = 1;
  localparam int PACC_FLG_IF = 0;
  localparam logic [7:0] PACC_CTL_RST = 8'h00;
  localparam logic [15:0] PACC_CNT_RST = 16'h0000;
  localparam logic [15:0] PACC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] PACC_CNT_ONE = 16'h0001;
  localparam logic [7:0] PACC_DIV256_MAX = 8'hFF;
  localparam logic [15:0] PACC_DIV64K_MAX = 16'hFFFF;
  localparam logic [1:0] PACC_CLK_PRESC = 2'h0;
  localparam logic [1:0] PACC_CLK_ACC = 2'h1;
  localparam logic [1:0] PACC_CLK_ACC256 = 2'h2;
  localparam logic [1:0] PACC_CLK_ACC64K = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pacc_bus_t;

  typedef struct packed {
    logic enable;
    logic mode_sel;
    logic edge_sel;
    logic [1:0] clk_sel;
    logic ovf_irq_en;
    logic input_irq_en;
  } pacc_ctl_t;
endpackage

// file: tb/pacc_pin_src.sv
// Pulse and gate source on the shared channel-7 pin
`timescale 1ns/100ps
`default_nettype none
module pacc_pin_src (
  input wire logic mclk,
  output logic pin
);
  // Sole driver of the pin, output compare side kept off it
  initial pin = 1'b0;
  // Full pulses, each level held w cycles, at least 3
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge mclk);
      pin <= ~pin;
      repeat (w) @(posedge mclk);
      pin <= ~pin;
      repeat (w) @(posedge mclk);
    end
  endtask
  // Gate level, held long enough to pass the synchroniser
  task automatic lvl(input logic v);
    @(posedge mclk);
    pin <= v;
    repeat (3) @(posedge mclk);
  endtask
endmodule // pacc_pin_src
`default_nettype wire

// file: tb/pacc_unit_tb.sv
// Self-checking bench for the pulse accumulator
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module pacc_unit_tb
  import pacc_pkg::*;
();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pacc_bus_t bus;
  logic [15:0] rdata;
  logic pin, timer_on, ffc, d64, ptk, tck, ovf_irq, input_irq;
  logic [1:0] pc;
  int n_fail, checks, n_tck, cyc;
  pacc_unit u_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .channel7_pin(pin), .timer_on(timer_on), .fast_flag_clear(ffc),
    .presc_div64_tick(d64), .presc_tick(ptk), .timer_clk_tick(tck),
    .ovf_irq(ovf_irq), .input_irq(input_irq));
  pacc_pin_src u_src (.mclk(mclk), .pin(pin));
  // ---------------------------------------
  // Clock, prescaler tick, tick count, timeout
  // ---------------------------------------
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    pc <= pc + 2'h1;
    ptk <= (pc == 2'h3);
    n_tck <= n_tck + int'(tck);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ---------------------------------------
  // Bus and helper tasks
  // ---------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      d64 <= 1'b1;
      @(posedge mclk);
      d64 <= 1'b0;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ---------------------------------------
  // Test sequence
  // ---------------------------------------
  initial begin
    bus = '0; timer_on = 1'b0; ffc = 1'b0; d64 = 1'b0; ptk = 1'b0;
    pc = 2'h0; n_tck = 0; cyc = 0; n_fail = 0; checks = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(PACC_ADDR_CTL, 16'h0000, "ctl");
    rd(PACC_ADDR_FLG, 16'h0000, "flg");
    rd(PACC_ADDR_CNT, 16'h0000, "cnt");
    rd(8'h30, 16'h0000, "unmapped");
    wr(PACC_ADDR_CTL, 16'h0050);
    u_src.pulses(5, 3);
    rd(PACC_ADDR_CNT, 16'h0005, "cnt");
    rd(PACC_ADDR_FLG, 16'h0001, "flg");
    wr(PACC_ADDR_FLG, 16'h0001);
    rd(PACC_ADDR_FLG, 16'h0000, "flg");
    wr(PACC_ADDR_CTL, 16'h0044);
    cy(2);
    n_tck = 0;
    u_src.pulses(3, 3);
    rd(PACC_ADDR_CNT, 16'h0008, "cnt");
    `CHK("tck acc", 3, n_tck)
    wr(PACC_ADDR_CTL, 16'h0004);
    u_src.pulses(2, 3);
    rd(PACC_ADDR_CNT, 16'h0008, "cnt");
    n_tck = 0;
    cy(40);
    `CHK("tck presc", 10, n_tck)
    wr(PACC_ADDR_CTL, 16'h0051);
    u_src.pulses(1, 3);
    #1 `CHK("input_irq", 1'b1, input_irq)
    wr(PACC_ADDR_CTL, 16'h0050);
    cy(2);
    `CHK("input_irq", 1'b0, input_irq)
    wr(PACC_ADDR_CNT, 16'hFFFF);
    wr(PACC_ADDR_CTL, 16'h0052);
    u_src.pulses(1, 3);
    rd(PACC_ADDR_CNT, 16'h0000, "cnt");
    rd(PACC_ADDR_FLG, 16'h0003, "flg");
    `CHK("ovf_irq", 1'b1, ovf_irq)
    wr(PACC_ADDR_FLG, 16'h0002);
    rd(PACC_ADDR_FLG, 16'h0001, "flg");
    `CHK("ovf_irq", 1'b0, ovf_irq)
    ffc <= 1'b1;
    rd(PACC_ADDR_CNT, 16'h0000, "cnt");
    rd(PACC_ADDR_FLG, 16'h0000, "flg");
    ffc <= 1'b0;
    wr(PACC_ADDR_CTL, 16'h0060);
    timer_on <= 1'b1;
    u_src.lvl(1'b1);
    tick(4);
    u_src.lvl(1'b0);
    rd(PACC_ADDR_CNT, 16'h0004, "cnt");
    rd(PACC_ADDR_FLG, 16'h0001, "flg");
    timer_on <= 1'b0;
    u_src.lvl(1'b1);
    tick(4);
    rd(PACC_ADDR_CNT, 16'h0004, "cnt");
    wr(PACC_ADDR_CTL, 16'h0070);
    timer_on <= 1'b1;
    u_src.lvl(1'b0);
    wr(PACC_ADDR_FLG, 16'h0001);
    tick(2);
    u_src.lvl(1'b1);
    tick(2);
    rd(PACC_ADDR_CNT, 16'h0006, "cnt");
    rd(PACC_ADDR_FLG, 16'h0001, "flg");
    wr(PACC_ADDR_CTL, 16'h0068);
    cy(2);
    n_tck = 0;
    tick(256);
    cy(3);
    `CHK("tck div256", 1, n_tck)
    report_and_stop();
  end
endmodule // pacc_unit_tb
`default_nettype wire
